// [pkg/lfg_map.vh]
// lfg_map.vh: register offsets, field positions, reset values and commands for lfg
// assumes: included by the lfg design files; definitions only
`ifndef LFG_MAP_VH
`define LFG_MAP_VH
// ************************************************************
// apb register byte addresses
// ************************************************************
`define LFG_OFF_SYSCFG   12'h000
`define LFG_OFF_VIS      12'h004
`define LFG_OFF_TOTAL    12'h008
`define LFG_OFF_FRAME    12'h00c
`define LFG_OFF_PITCH_LO 12'h010
`define LFG_OFF_PITCH_HI 12'h014
`define LFG_OFF_CMD      12'h018
`define LFG_OFF_STATUS   12'h01c
`define LFG_OFF_PITCH    12'h020
// ************************************************************
// syscfg fields
// ************************************************************
`define LFG_CFG_DUAL_BIT 7
`define LFG_CFG_FXW_LSB  0
`define LFG_CFG_FXW_MSB  2
// ************************************************************
// command codes written to the command register
// ************************************************************
`define LFG_CMD_SLEEP    8'h53
`define LFG_CMD_DISPLAY_ENABLE_CMD  8'h59
`define LFG_CMD_DISP_OFF 8'h58
// ************************************************************
// reset values and limits
// ************************************************************
`define LFG_RST_VIS      8'h27
`define LFG_RST_TOTAL    8'h2b
`define LFG_RST_FRAME    8'h3f
`define LFG_RST_PITCH    16'h0028
`define LFG_RST_SYSCFG   8'h07
`define LFG_VIS_MAX      8'hef
`define LFG_BLANK_FRAMES 2'h2
// ************************************************************
// status bits
// ************************************************************
`define LFG_ST_ASLEEP    0
`define LFG_ST_DISP      1
`define LFG_ST_ROWDIS    2
`define LFG_ST_PENDING   3
`endif

// [rtl/lfg_frame_cnt.v]
// lfg_frame_cnt: line counter wrapping at the frame height
// assumes: line_step is a one-cycle pulse at the end of each line
`timescale 1ns/1ps
module lfg_frame_cnt (
    input  wire       clk,
    input  wire       nrst,
    input  wire       restart,
    input  wire       line_step,
    input  wire [7:0] frame_lines,
    output reg  [7:0] line_pos,
    output wire       frame_end
);
    assign frame_end = line_step && (line_pos >= frame_lines);

    always @(posedge clk) begin
        if (!nrst || restart) begin
            line_pos <= 8'h00;
        end else if (frame_end) begin
            line_pos <= 8'h00;
        end else if (line_step) begin
            line_pos <= line_pos + 8'h01;
        end
    end
endmodule

// [rtl/lfg_line_cnt.v]
// lfg_line_cnt: byte counter wrapping at the total line length, with blanking flag
// assumes: one byte period per clk, advanced only while run is high
`timescale 1ns/1ps
module lfg_line_cnt (
    input  wire       clk,
    input  wire       nrst,
    input  wire       restart,
    input  wire       run,
    input  wire [7:0] total_line_length,
    input  wire [7:0] visible_bytes,
    output reg  [7:0] byte_pos,
    output wire       line_end,
    output wire       hblank
);
    // a total shortened below the current position ends the line at once
    assign line_end = run && (byte_pos >= total_line_length);
    // bytes past the visible count are blank, which covers both surplus and retrace
    assign hblank = (byte_pos > visible_bytes);

    always @(posedge clk) begin
        if (!nrst || restart) begin
            byte_pos <= 8'h00;
        end else if (line_end) begin
            byte_pos <= 8'h00;
        end else if (run) begin
            byte_pos <= byte_pos + 8'h01;
        end
    end
endmodule

// [rtl/lfg_top.v]
// lfg_top: frame geometry, line/frame timing and standby control of an lcd controller
// assumes: apb master on clk; memory control and host bus pins live outside, gated here
`timescale 1ns/1ps
`include "lfg_map.vh"
module lfg_top (
    input  wire        clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire [7:0]  mem_ctl_in,
    output reg  [7:0]  mem_ctl,
    output reg         col_data_blank,
    output reg         row_driver_disable,
    output wire        host_bus_oe,
    output wire        osc_run,
    output reg         line_pulse,
    output reg         frame_pulse,
    output reg         dual_panel,
    output reg  [3:0]  char_width,
    output reg  [7:0]  line_index
);
    // ************************************************************
    // register storage
    // ************************************************************
    reg  [7:0]  sys_cfg;
    reg  [7:0]  visible_bytes;
    reg  [7:0]  total_line_length;
    reg  [7:0]  frame_lines;
    reg  [15:0] virtual_line_pitch;
    reg  [7:0]  pitch_low_byte;
    reg         pitch_low_seen;
    reg         vis_err;
    reg         display_enable_cmd;
    reg  [1:0]  sleep_frames;
    reg         restart;
    reg  [1:0]  slp_state;
    reg  [1:0]  next_slp_state;
    reg  [1:0]  next_sleep_frames;
    reg         next_display_enable_cmd;
    reg         next_row_driver_disable;
    reg         next_restart;
    reg  [31:0] next_prdata;

    wire        wr_en;
    wire        rd_en;
    wire [7:0]  wbyte;
    wire [7:0]  byte_pos;
    wire [7:0]  line_pos;
    wire        line_end;
    wire        hblank;
    wire        frame_end;
    wire        timing_run;
    wire        asleep;
    wire        sleep_pending;
    wire        cfg_hit;
    wire        cmd_hit;

    function known_addr;
        input [11:0] a;
        begin
            case (a)
                `LFG_OFF_SYSCFG, `LFG_OFF_VIS, `LFG_OFF_TOTAL, `LFG_OFF_FRAME,
                `LFG_OFF_PITCH_LO, `LFG_OFF_PITCH_HI, `LFG_OFF_CMD,
                `LFG_OFF_STATUS, `LFG_OFF_PITCH: known_addr = 1'b1;
                default: known_addr = 1'b0;
            endcase
        end
    endfunction

    // byte-wide register fields read back with the upper bits zero
    function [31:0] widen8;
        input [7:0] b;
        begin
            widen8 = {24'h000000, b};
        end
    endfunction

    function [3:0] fx_to_width;
        input [2:0] fx;
        begin
            fx_to_width = {1'b0, fx} + 4'h1;
        end
    endfunction

    // ************************************************************
    // apb slave: zero wait states, error on unmapped address
    // ************************************************************
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !known_addr(paddr);
    assign wr_en   = psel && penable && pwrite && known_addr(paddr);
    assign rd_en   = psel && !penable && !pwrite;
    assign wbyte   = pwdata[7:0];

    // ************************************************************
    // configuration writes
    // ************************************************************
    always @(posedge clk) begin
        if (!nrst) begin
            sys_cfg            <= `LFG_RST_SYSCFG;
            visible_bytes      <= `LFG_RST_VIS;
            total_line_length  <= `LFG_RST_TOTAL;
            frame_lines        <= `LFG_RST_FRAME;
            virtual_line_pitch <= `LFG_RST_PITCH;
            pitch_low_byte     <= 8'h00;
            pitch_low_seen     <= 1'b0;
            vis_err            <= 1'b0;
        end else if (wr_en && (!asleep || paddr == `LFG_OFF_SYSCFG)) begin
            // while asleep only the wake write is honoured; geometry is held
            case (paddr)
                `LFG_OFF_VIS: begin
                    if (wbyte > `LFG_VIS_MAX) begin
                        vis_err <= 1'b1;
                    end else begin
                        visible_bytes <= wbyte;
                        vis_err       <= 1'b0;
                    end
                end
                `LFG_OFF_SYSCFG:   sys_cfg <= wbyte;
                `LFG_OFF_TOTAL:    total_line_length <= wbyte;
                `LFG_OFF_FRAME:    frame_lines <= wbyte;
                `LFG_OFF_PITCH_LO: begin
                    pitch_low_byte <= wbyte;
                    pitch_low_seen <= 1'b1;
                end
                `LFG_OFF_PITCH_HI: begin
                    // the pitch changes as one word only once the high byte lands
                    if (pitch_low_seen) begin
                        virtual_line_pitch <= {wbyte, pitch_low_byte};
                    end else begin
                        virtual_line_pitch[15:8] <= wbyte;
                    end
                    pitch_low_seen <= 1'b0;
                end
                default: begin
                    pitch_low_seen <= pitch_low_seen;
                end
            endcase
        end
    end

    // ************************************************************
    // derived geometry
    // ************************************************************
    always @(posedge clk) begin
        if (!nrst) begin
            dual_panel <= 1'b0;
            char_width <= 4'h8;
        end else begin
            dual_panel <= sys_cfg[`LFG_CFG_DUAL_BIT];
            char_width <= fx_to_width(sys_cfg[`LFG_CFG_FXW_MSB:`LFG_CFG_FXW_LSB]);
        end
    end

    // ************************************************************
    // sleep, wake and display control
    // ************************************************************
    // the first boundary after the command ends a partial frame,
    // so the second one lies one to two frames on
    localparam [1:0] SLP_AWAKE  = 2'b00;
    localparam [1:0] SLP_DRAIN  = 2'b01;
    localparam [1:0] SLP_HALTED = 2'b10;

    assign cfg_hit       = wr_en && (paddr == `LFG_OFF_SYSCFG);
    assign cmd_hit       = wr_en && !asleep && (paddr == `LFG_OFF_CMD);
    assign asleep        = (slp_state == SLP_HALTED);
    assign sleep_pending = (slp_state == SLP_DRAIN);

    always @* begin
        next_slp_state          = slp_state;
        next_sleep_frames       = sleep_frames;
        next_display_enable_cmd            = display_enable_cmd;
        next_row_driver_disable = row_driver_disable;
        next_restart            = 1'b0;
        if (cfg_hit) begin
            // first config byte: restart timing, display off, wake
            next_restart            = 1'b1;
            next_display_enable_cmd            = 1'b0;
            next_slp_state          = SLP_AWAKE;
            next_sleep_frames       = 2'h0;
            next_row_driver_disable = 1'b1;
        end else begin
            if (cmd_hit && wbyte == `LFG_CMD_DISPLAY_ENABLE_CMD) begin
                next_display_enable_cmd = 1'b1;
            end else if (cmd_hit && wbyte == `LFG_CMD_DISP_OFF) begin
                next_display_enable_cmd = 1'b0;
            end
            case (slp_state)
                SLP_AWAKE: begin
                    if (cmd_hit && wbyte == `LFG_CMD_SLEEP) begin
                        next_slp_state    = SLP_DRAIN;
                        next_sleep_frames = 2'h0;
                    end
                end
                SLP_DRAIN: begin
                    // a command write on a boundary edge does not hide the boundary
                    if (frame_end) begin
                        next_sleep_frames = sleep_frames + 2'h1;
                        if (sleep_frames == 2'h1) begin
                            next_row_driver_disable = 1'b0;
                        end
                        if (sleep_frames + 2'h1 == `LFG_BLANK_FRAMES) begin
                            next_slp_state = SLP_HALTED;
                        end
                    end
                end
                SLP_HALTED: begin
                    next_slp_state = SLP_HALTED;
                end
                default: begin
                    next_slp_state = SLP_AWAKE;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            slp_state          <= SLP_AWAKE;
            sleep_frames       <= 2'h0;
            display_enable_cmd            <= 1'b0;
            row_driver_disable <= 1'b1;
            restart            <= 1'b0;
        end else begin
            slp_state          <= next_slp_state;
            sleep_frames       <= next_sleep_frames;
            display_enable_cmd            <= next_display_enable_cmd;
            row_driver_disable <= next_row_driver_disable;
            restart            <= next_restart;
        end
    end

    assign timing_run  = !asleep;
    assign osc_run     = !asleep;
    assign host_bus_oe = !asleep;

    // ************************************************************
    // line and frame counters
    // ************************************************************
    lfg_line_cnt u_line (
        .clk               (clk),
        .nrst              (nrst),
        .restart           (restart),
        .run               (timing_run),
        .total_line_length (total_line_length),
        .visible_bytes     (visible_bytes),
        .byte_pos          (byte_pos),
        .line_end          (line_end),
        .hblank            (hblank)
    );

    lfg_frame_cnt u_frame (
        .clk         (clk),
        .nrst        (nrst),
        .restart     (restart),
        .line_step   (line_end),
        .frame_lines (frame_lines),
        .line_pos    (line_pos),
        .frame_end   (frame_end)
    );

    // ************************************************************
    // driver-side outputs
    // ************************************************************
    always @(posedge clk) begin
        if (!nrst) begin
            col_data_blank <= 1'b1;
            line_pulse     <= 1'b0;
            frame_pulse    <= 1'b0;
            line_index     <= 8'h00;
            mem_ctl        <= 8'h00;
        end else begin
            // blank from the moment standby is requested onward
            col_data_blank <= hblank || !display_enable_cmd || sleep_pending || asleep;
            line_pulse     <= line_end;
            frame_pulse    <= frame_end;
            line_index     <= line_pos;
            if (!asleep) begin
                mem_ctl <= mem_ctl_in;
            end else begin
                mem_ctl <= mem_ctl;
            end
        end
    end

    // ************************************************************
    // read mux, registered on the setup cycle
    // ************************************************************
    always @* begin
        next_prdata = prdata;
        if (rd_en) begin
            case (paddr)
                `LFG_OFF_SYSCFG:   next_prdata = widen8(sys_cfg);
                `LFG_OFF_VIS:      next_prdata = widen8(visible_bytes);
                `LFG_OFF_TOTAL:    next_prdata = widen8(total_line_length);
                `LFG_OFF_FRAME:    next_prdata = widen8(frame_lines);
                `LFG_OFF_PITCH_LO: next_prdata = widen8(virtual_line_pitch[7:0]);
                `LFG_OFF_PITCH_HI: next_prdata = widen8(virtual_line_pitch[15:8]);
                `LFG_OFF_PITCH:    next_prdata = {16'h0000, virtual_line_pitch};
                `LFG_OFF_STATUS:   next_prdata = {27'h0000000, vis_err, sleep_pending,
                                                  row_driver_disable, display_enable_cmd, asleep};
                default:           next_prdata = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= next_prdata;
        end
    end
endmodule

// [verif/lfg_frame_geometry_sleep_tb.sv]
// lfg_frame_geometry_sleep_tb: register, line/frame timing and standby scenarios
// assumes: lfg_top with zero-wait apb; host model drives the bus
`timescale 1ns/1ps
`include "lfg_map.vh"
module lfg_frame_geometry_sleep_tb;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, rd_valid, hung;
    logic clk_blank, rdis, oe, osc, lp, fp, dual;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  mem_ctl_in, mem_ctl, lidx;
    logic [3:0]  cw;
    logic [32:0] rd_res;
    logic [33:0] exp_q[$];
    logic [31:0] seed;
    int fails, n_compared, n, v, k;
    lfg_host_model i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rd_valid(rd_valid), .rd_res(rd_res), .hung(hung));
    lfg_top i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .mem_ctl_in(mem_ctl_in), .mem_ctl(mem_ctl), .col_data_blank(clk_blank),
        .row_driver_disable(rdis), .host_bus_oe(oe), .osc_run(osc), .line_pulse(lp),
        .frame_pulse(fp), .dual_panel(dual), .char_width(cw), .line_index(lidx));
    // ****
    // helpers
    // ****
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    always @(posedge clk) mem_ctl_in <= 8'(xs());
    task cmp(input logic [32:0] got, input logic [32:0] e);
        n_compared++;
        if (got !== e) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task cmp_rd(input logic [32:0] got, input logic [33:0] e);
        n_compared++;
        if (e[33] ? got !== e[32:0] : got[32] !== e[32]) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e[32:0]);
        end
    endtask
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) fails++;
            else cmp_rd(rd_res, exp_q.pop_front());
        end
    end
    task wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back({2'b10, e});
        i_host.xfer(1'b0, a, 32'h0);
    endtask
    // cycles from one pulse to the next, and unblanked bytes among them
    task span(input logic frm, output int n, output int v);
        k = 0;
        while ((frm ? fp : lp) !== 1'b1 && k < 999) begin
            @(posedge clk);
            k++;
        end
        n = 0;
        v = 0;
        do begin
            @(posedge clk);
            n++;
            v += (clk_blank === 1'b0);
        end while ((frm ? fp : lp) !== 1'b1 && n < 999);
        if (k >= 999 || n >= 999) begin
            fails++;
            print_verdict();
        end
    endtask
    task print_verdict;
        if (hung === 1'b1 || exp_q.size() != 0) fails++;
        $display("compared=%0d failed=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #1250000;
        fails++;
        print_verdict();
    end
    // ****
    // scenarios
    // ****
    initial begin
        nrst <= 1'b0;
        seed = 32'h079a6469;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        cmp({cw, dual, rdis, osc}, {4'h8, 1'b0, 1'b1, 1'b1});
        rd(`LFG_OFF_SYSCFG, 32'h07);
        rd(`LFG_OFF_VIS, 32'h27);
        rd(`LFG_OFF_TOTAL, 32'h2b);
        rd(`LFG_OFF_FRAME, 32'h3f);
        rd(`LFG_OFF_PITCH, 32'h28);
        for (int w = 0; w < 8; w++) begin
            wr(`LFG_OFF_SYSCFG, {24'h0, w[0], 4'h0, w[2:0]});
            @(negedge clk);
            cmp({dual, cw}, {w[0], 4'(w + 1)});
            @(posedge clk);
        end
        exp_q.push_back({2'b01, 32'h0});
        i_host.xfer(1'b0, 12'h024, 32'h0);
        wr(`LFG_OFF_TOTAL, 32'hff);
        wr(`LFG_OFF_VIS, 32'hef);
        rd(`LFG_OFF_VIS, 32'hef);
        wr(`LFG_OFF_VIS, 32'hf0);
        rd(`LFG_OFF_VIS, 32'hef);
        rd(`LFG_OFF_STATUS, 32'h14);
        r = xs();
        wr(`LFG_OFF_PITCH_LO, {24'h0, r[7:0]});
        wr(`LFG_OFF_PITCH_HI, {24'h0, r[15:8]});
        rd(`LFG_OFF_PITCH, {16'h0, r[15:0]});
        rd(`LFG_OFF_PITCH_HI, {24'h0, r[15:8]});
        // small geometry keeps a frame at 32 clocks
        wr(`LFG_OFF_SYSCFG, 32'h82);
        wr(`LFG_OFF_VIS, 32'h03);
        wr(`LFG_OFF_TOTAL, 32'h07);
        wr(`LFG_OFF_FRAME, 32'h03);
        wr(`LFG_OFF_CMD, `LFG_CMD_DISPLAY_ENABLE_CMD);
        span(1'b0, n, v);
        cmp(n, 8);
        cmp(v, 4);
        span(1'b1, n, v);
        cmp(n, 32);
        cmp(lidx, 8'h03);
        wr(`LFG_OFF_CMD, `LFG_CMD_DISP_OFF);
        span(1'b0, n, v);
        cmp(v, 0);
        wr(`LFG_OFF_CMD, `LFG_CMD_SLEEP);
        k = 1;
        while (rdis === 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        cmp(k >= 32 && k <= 66, 1);
        cmp({osc, oe, clk_blank}, 3'b001);
        r = mem_ctl;
        wr(`LFG_OFF_VIS, 32'h55);
        repeat (10) @(posedge clk);
        cmp(mem_ctl, r[7:0]);
        wr(`LFG_OFF_SYSCFG, 32'h83);
        cmp({rdis, osc, oe}, 3'b111);
        rd(`LFG_OFF_SYSCFG, 32'h83);
        rd(`LFG_OFF_VIS, 32'h03);
        rd(`LFG_OFF_TOTAL, 32'h07);
        span(1'b0, n, v);
        cmp({n, v}, {32'd8, 32'd0});
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule

// [verif/lfg_host_model.sv]
// lfg_host_model: apb master standing in for the host processor
// assumes: caller enters xfer just after a rising clk edge
`timescale 1ns/1ps
module lfg_host_model (
    input  wire        clk,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [11:0] paddr,
    output reg  [31:0] pwdata,
    input  wire        pready,
    input  wire [31:0] prdata,
    input  wire        pslverr,
    output reg         rd_valid,
    output reg  [32:0] rd_res,
    output reg         hung
);
    // ****
    // one transfer; request held until pready seen high or 64 cycles pass
    // ****
    initial begin
        {psel, penable, pwrite, rd_valid, hung} = 5'b00000;
        paddr  = 12'h000;
        pwdata = 32'h00000000;
        rd_res = 33'h000000000;
    end
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        hung     <= hung | (n >= 64);
        rd_valid <= !w;
        rd_res   <= {pslverr, prdata};
        psel     <= 1'b0;
        penable  <= 1'b0;
        @(posedge clk);
        rd_valid <= 1'b0;
    endtask
endmodule

// [verif/lfg_top_sva.sv]
// lfg_top_sva: port-level checks of timing, standby and wake-up
// assumes: bound into lfg_top; apb writes land with psel and penable high
`timescale 1ns/1ps
`include "lfg_map.vh"
module lfg_top_sva (
    input logic        clk,
    input logic        nrst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [7:0]  mem_ctl_in,
    input logic [7:0]  mem_ctl,
    input logic        col_data_blank,
    input logic        row_driver_disable,
    input logic        host_bus_oe,
    input logic        osc_run,
    input logic        line_pulse,
    input logic        frame_pulse,
    input logic        dual_panel,
    input logic [3:0]  char_width
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ****
    // frames seen since the standby command
    // ****
    logic [1:0] fcnt;
    logic       armed;
    wire acc    = psel && penable && pwrite;
    wire cfg_wr = acc && paddr == `LFG_OFF_SYSCFG;
    wire slp_wr = acc && paddr == `LFG_OFF_CMD && pwdata[7:0] == `LFG_CMD_SLEEP;
    always @(posedge clk) begin
        if (!nrst || cfg_wr) begin
            fcnt  <= 2'h0;
            armed <= 1'b0;
        end else if (slp_wr) begin
            fcnt  <= 2'h0;
            armed <= 1'b1;
        end else if (armed && frame_pulse && fcnt != 2'h3) begin
            fcnt <= fcnt + 2'h1;
        end
    end
    // ****
    // assertions
    // ****
    a_frame_on_line: assert property (frame_pulse |-> line_pulse)
        else $error("frame end off a line end");
    a_asleep_pins: assert property (!osc_run |-> !host_bus_oe && col_data_blank
        && !row_driver_disable) else $error("sleep pins wrong");
    a_mem_frozen: assert property (!osc_run && $past(osc_run) == 1'b0 |-> $stable(mem_ctl))
        else $error("memory control moved asleep");
    a_mem_follow: assert property ($past(osc_run) && $past(nrst)
        |-> mem_ctl == $past(mem_ctl_in)) else $error("memory control not copied");
    a_wake_release: assert property (cfg_wr |=> row_driver_disable && osc_run
        && host_bus_oe) else $error("wake not taken");
    a_cfg_fields: assert property (cfg_wr |-> ##2 dual_panel == $past(pwdata[7], 2)
        && char_width == {1'b0, $past(pwdata[2:0], 2)} + 4'h1) else $error("width or panel");
    a_rowdis_window: assert property ($fell(row_driver_disable)
        |-> armed && fcnt >= 2'h1 && fcnt <= 2'h2) else $error("row disable off window");
    a_halt_after_frame: assert property (!osc_run && $past(osc_run) |-> fcnt >= 2'h1)
        else $error("halted before a blank frame");
endmodule
bind lfg_top lfg_top_sva i_sva (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .mem_ctl_in(mem_ctl_in),
    .mem_ctl(mem_ctl), .col_data_blank(col_data_blank),
    .row_driver_disable(row_driver_disable), .host_bus_oe(host_bus_oe), .osc_run(osc_run),
    .line_pulse(line_pulse), .frame_pulse(frame_pulse), .dual_panel(dual_panel),
    .char_width(char_width));
